// [core/commutator_pkg.sv]
// Constants shared by the commutator core and its dead-time phase module
package commutator_pkg;
  // ==========================================================================
  // Carrier and bootstrap timing
  localparam int CARRIER_CYCLES = 252;
  localparam logic [7:0] CARRIER_LAST = 8'(CARRIER_CYCLES - 1);
  localparam logic [7:0] CARRIER_HALF = 8'(CARRIER_CYCLES / 2);
  localparam int FORCED_LOWER_PERCENT = 8;
  localparam logic [7:0] FORCED_LOWER_ON_CYCLES = 8'(CARRIER_CYCLES * FORCED_LOWER_PERCENT / 100);
  // ==========================================================================
  // Dead time in reference clock periods
  localparam logic [4:0] DEAD_CYCLES_HIGH = 5'h0B;
  localparam logic [4:0] DEAD_CYCLES_LOW = 5'h10;
  // ==========================================================================
  // Square to sine switch-over, one 60 degree sector in cycles
  localparam int SWITCH_PRESCALE = 4096;
  localparam int SAMPLES_PER_SECTOR = 32;
  localparam int SECTORS_PER_TURN = 6;
  localparam int SINE_SWITCH_SECTOR_CYCLES = SWITCH_PRESCALE * SAMPLES_PER_SECTOR;
  localparam int SAMPLE_SHIFT = 5;
  localparam logic [4:0] SAMPLE_LAST = 5'h1F;
  localparam logic [2:0] SECTOR_LAST = 3'h5;
  // ==========================================================================
  // Electrical position, 192 samples per turn
  localparam logic [7:0] POSITIONS = 8'hC0;
  localparam logic [7:0] POS_BACK = 8'hBF;
  localparam logic [7:0] POS_FWD = 8'h01;
  localparam logic [7:0] PHASE_SHIFT = 8'h40;
  localparam logic [7:0] HALF_TURN = 8'h60;
  localparam logic [7:0] QUARTER_TURN = 8'h30;
  localparam logic [7:0] MOD_CENTER = 8'h3F;
  // ==========================================================================
  // Speed command code at or below 0.2 V of a 5 V, 8-bit scale
  localparam logic [7:0] SPEED_LOW_CODE_DEFAULT = 8'h0A;
  // ==========================================================================
  // Hall code per sector, square pattern per sector (bit i upper, 3+i lower)
  localparam logic [2:0] HALL_CODE [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  localparam logic [5:0] SQUARE_PATTERN [6] = '{6'h11, 6'h21, 6'h22, 6'h0A, 6'h0C, 6'h14};
  // ==========================================================================
  // Quarter sine, 49 points, peak 62
  localparam logic [5:0] SINE_QUARTER [49] = '{
    6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12, 6'h14, 6'h16, 6'h18,
    6'h1A, 6'h1B, 6'h1D, 6'h1F, 6'h21, 6'h22, 6'h24, 6'h26, 6'h27, 6'h29, 6'h2A, 6'h2C, 6'h2D,
    6'h2F, 6'h30, 6'h31, 6'h32, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h38, 6'h39, 6'h3A, 6'h3B,
    6'h3B, 6'h3C, 6'h3C, 6'h3D, 6'h3D, 6'h3D, 6'h3E, 6'h3E, 6'h3E, 6'h3E};
endpackage

// [core/dead_time_phase.sv]
// One bridge leg: complementary outputs with counted dead time
`timescale 1ns/100ps
`default_nettype none
module dead_time_phase (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic want_upper_i,
  input wire logic want_lower_i,
  input wire logic [4:0] dead_cycles_i,
  output logic upper_on_o,
  output logic lower_on_o
);
  import commutator_pkg::*;

  typedef struct packed {
    logic up;
    logic lo;
    logic [4:0] cnt;
  } leg_type;

  leg_type leg_reg, leg_next;

  // ==========================================================================
  // Leg control
  always_comb begin
    leg_next = leg_reg;
    if (leg_reg.cnt != 5'h00) begin
      leg_next.cnt = leg_reg.cnt - 5'h01;
    end
    // RQ10 - dead length loaded
    if (leg_reg.up && !want_upper_i) begin
      leg_next.up = 1'b0;
      leg_next.cnt = dead_cycles_i - 5'h01;
    end
    if (leg_reg.lo && !want_lower_i) begin
      leg_next.lo = 1'b0;
      leg_next.cnt = dead_cycles_i - 5'h01;
    end
    // RQ26 - complementary turn-on
    if (!leg_reg.up && !leg_reg.lo && leg_reg.cnt == 5'h00) begin
      leg_next.up = want_upper_i && !want_lower_i;
      leg_next.lo = want_lower_i && !want_upper_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      leg_reg <= '0;
    end else begin
      leg_reg <= leg_next;
    end
  end

  assign upper_on_o = leg_reg.up;
  assign lower_on_o = leg_reg.lo;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_lower_off;
    $fell(leg_reg.lo);
  endsequence

  property p_no_overlap;
    !(leg_reg.up && leg_reg.lo);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("upper and lower on together"); // RQ8

  property p_dead_gap;
    s_lower_off |-> (!leg_reg.up) [*8];
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("upper on inside dead time"); // RQ26
endmodule
`default_nettype wire

// [core/sine_pwm_bldc_commutator.sv]
// Three-phase Hall-driven square/sine PWM commutator core
// Operation
// RQ1 - Start in 120 degree square drive from Hall inputs until switch-over speed.
// RQ2 - Switch-over rate is clock over 4096 times 32 times 6.
// RQ3 - Above switch-over, build modulation wave and drive 180 degree sine PWM.
// RQ4 - Low speed command forces lowers on once per carrier, about 8% duty.
// RQ5 - Above low command in sine drive, PWM passes to outputs unchanged.
// RQ6 - Above low command in square drive, lowers still forced on each carrier.
// RQ7 - System holds speed command low at start-up to precharge bootstrap supplies.
// RQ8 - Sine drive inserts counted dead time; upper and lower never both on.
// RQ9 - Square drive at full duty also keeps dead-time interlock.
// RQ10 - Dead time is 11 clocks with select high, 16 clocks with it low.
// RQ11 - Lead angle 0 to 58 degrees in 32 steps, saturating at 58.
// RQ12 - Carrier period is 252 clock periods.
// RQ13 - Polarity select high gives active-high outputs, low gives active-low.
// RQ14 - Direction checked every 360 degrees; flag high on mismatch, high after reset.
// RQ15 - Sine drive only while reverse flag low, else square drive.
// RQ16 - Over-current trip blocks all gates, released at next carrier cycle.
// RQ17 - Gate-block input low holds all outputs inactive; resume when high.
// RQ18 - Gate-block input low also suppresses bootstrap pulses.
// RQ19 - Hall pattern all high or all low turns all outputs off.
// RQ20 - Time between Hall edges paces the next 60 degree sector.
// RQ21 - Each sector has 32 samples, each one 32nd of last sector time.
// RQ22 - Without a new edge, stepping continues at the same width.
// RQ23 - Every Hall edge restarts the modulation wave for its sector.
// RQ24 - Forced lower on-time is 8% of carrier, regardless of speed command.
// RQ25 - Forced lower turn-on switches upper off first with dead time.
// RQ26 - Upper and lower derived complementarily, dead time delaying each turn-on.
`timescale 1ns/100ps
`default_nettype none
module sine_pwm_bldc_commutator #(
  parameter int SWITCH_CYCLES = commutator_pkg::SINE_SWITCH_SECTOR_CYCLES,
  parameter logic [7:0] SPEED_LOW_CODE = commutator_pkg::SPEED_LOW_CODE_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hall_phase_a_i,
  input wire logic hall_phase_b_i,
  input wire logic hall_phase_c_i,
  input wire logic direction_select_i,
  input wire logic dead_time_select_i,
  input wire logic output_polarity_select_i,
  input wire logic gate_block_input_n_i,
  input wire logic overcurrent_trip_i,
  input wire logic [7:0] speed_command_i,
  input wire logic [4:0] lead_angle_input_i,
  output logic upper_a_o,
  output logic upper_b_o,
  output logic upper_c_o,
  output logic lower_a_o,
  output logic lower_b_o,
  output logic lower_c_o,
  output logic reverse_detect_flag_o
);
  import commutator_pkg::*;

  localparam int TW = $clog2(SWITCH_CYCLES + 1);
  localparam logic [TW-1:0] SW = TW'(SWITCH_CYCLES);
  localparam int SYNC_W = 21;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [2:0] hall_prev;
    logic [2:0] sector;
    logic [TW-1:0] tmr;
    logic [TW-1:0] period;
    logic [TW-1:0] stepcnt;
    logic [7:0] pos;
    logic fast;
    logic reverse_detect_flag;
    logic [2:0] edges;
    logic [7:0] cpos;
    logic oc_block;
    logic [2:0] want_up;
    logic [2:0] want_lo;
    logic [5:0] out;
  } state_type;

  state_type state_reg, state_next;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] pos_add(input logic [7:0] p, input logic [7:0] d);
    logic [8:0] s;
    s = {1'b0, p} + {1'b0, d};
    if (s >= {1'b0, POSITIONS}) begin
      s = s - {1'b0, POSITIONS};
    end
    return s[7:0];
  endfunction

  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    logic [2:0] s;
    s = 3'h0;
    for (int k = 0; k < 6; k++) begin
      if (HALL_CODE[k] == h) begin
        s = 3'(k);
      end
    end
    return s;
  endfunction

  function automatic logic [7:0] mod_level(input logic [7:0] p, input logic [7:0] amp);
    logic [7:0] h;
    logic [7:0] q;
    logic [13:0] prod;
    h = (p >= HALF_TURN) ? 8'(p - HALF_TURN) : p;
    q = (h > QUARTER_TURN) ? 8'(HALF_TURN - h) : h;
    prod = 14'(SINE_QUARTER[q[5:0]]) * 14'(amp);
    if (p >= HALF_TURN) begin
      return 8'(MOD_CENTER - {2'b00, prod[13:8]});
    end
    return 8'(MOD_CENTER + {2'b00, prod[13:8]});
  endfunction

  // ==========================================================================
  // Synchronised pins and decodes
  logic [2:0] hall;
  logic dir_s;
  logic dts_s;
  logic pol_s;
  logic gbn_s;
  logic oc_s;
  logic [7:0] speed_s;
  logic [4:0] lead_s;
  logic hall_ok;
  logic hall_edge;
  logic [2:0] sector_now;
  logic fwd;
  logic speed_low;
  logic blocked;
  logic [7:0] tri_lvl;
  logic boot_win;
  logic sine_mode;
  logic [4:0] dead_len;
  logic [2:0] up_on;
  logic [2:0] lo_on;

  assign {lead_s, speed_s, oc_s, gbn_s, pol_s, dts_s, dir_s, hall} = state_reg.sync2;
  // RQ19 - invalid Hall patterns
  assign hall_ok = (hall != 3'h0) && (hall != 3'h7);
  assign hall_edge = hall_ok && (hall != state_reg.hall_prev);
  assign sector_now = hall_sector(hall);
  assign fwd = (sector_now == ((state_reg.sector == SECTOR_LAST) ? 3'h0 : state_reg.sector + 3'h1));
  assign speed_low = speed_s <= SPEED_LOW_CODE;
  // RQ17 - gate block and faults
  assign blocked = !gbn_s || state_reg.oc_block || !hall_ok;
  // RQ12 - triangle from carrier count
  assign tri_lvl = (state_reg.cpos < CARRIER_HALF) ? state_reg.cpos : 8'(CARRIER_LAST - state_reg.cpos);
  // RQ24 - fixed forced lower window
  assign boot_win = state_reg.cpos < FORCED_LOWER_ON_CYCLES;
  // RQ15 - sine needs forward flag
  assign sine_mode = state_reg.fast && !state_reg.reverse_detect_flag;
  // RQ10 - dead length select
  assign dead_len = dts_s ? DEAD_CYCLES_HIGH : DEAD_CYCLES_LOW;

  // ==========================================================================
  // Bridge legs
  for (genvar i = 0; i < 3; i++) begin : g_leg
    dead_time_phase u_leg (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .want_upper_i(state_reg.want_up[i]),
      .want_lower_i(state_reg.want_lo[i]),
      .dead_cycles_i(dead_len),
      .upper_on_o(up_on[i]),
      .lower_on_o(lo_on[i])
    );
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [7:0] base;
    logic [7:0] ph;
    logic [7:0] sh;
    logic [5:0] pat;
    logic [5:0] on;
    logic [TW-1:0] width;
    logic pwm_up;
    logic sq_on;
    base = 8'h00;
    ph = 8'h00;
    sh = 8'h00;
    pat = 6'h00;
    on = 6'h00;
    width = '0;
    pwm_up = 1'b0;
    sq_on = 1'b0;
    state_next = state_reg;
    state_next.sync1 = {lead_angle_input_i, speed_command_i, overcurrent_trip_i, gate_block_input_n_i,
                        output_polarity_select_i, dead_time_select_i, direction_select_i,
                        hall_phase_a_i, hall_phase_b_i, hall_phase_c_i};
    state_next.sync2 = state_reg.sync1;

    // RQ12 - carrier of 252 clocks
    state_next.cpos = (state_reg.cpos == CARRIER_LAST) ? 8'h00 : state_reg.cpos + 8'h01;

    // RQ16 - trip sets, carrier end clears
    if (oc_s) begin
      state_next.oc_block = 1'b1;
    end else if (state_reg.cpos == CARRIER_LAST) begin
      state_next.oc_block = 1'b0;
    end

    if (hall_ok) begin
      state_next.hall_prev = hall;
    end
    width = state_reg.period >> SAMPLE_SHIFT;
    if (hall_edge) begin
      // RQ20 - sector time captured
      state_next.period = state_reg.tmr;
      // RQ2 - switch-over compare
      state_next.fast = state_reg.tmr < SW;
      state_next.tmr = '0;
      state_next.stepcnt = '0;
      state_next.sector = sector_now;
      // RQ23 - restart at sector start
      state_next.pos = dir_s ? {sector_now, SAMPLE_LAST} : {sector_now, 5'h00};
      // RQ14 - verdict every six edges
      if (state_reg.edges == SECTOR_LAST) begin
        state_next.edges = 3'h0;
        state_next.reverse_detect_flag = (fwd == dir_s);
      end else begin
        state_next.edges = state_reg.edges + 3'h1;
      end
    end else begin
      if (state_reg.tmr < SW) begin
        state_next.tmr = state_reg.tmr + 1'b1;
      end else begin
        state_next.fast = 1'b0;
      end
      // RQ21 - one sample per period/32
      // RQ22 - keep stepping past 32
      if (TW'(state_reg.stepcnt + 1'b1) >= width) begin
        state_next.stepcnt = '0;
        state_next.pos = pos_add(state_reg.pos, dir_s ? POS_BACK : POS_FWD);
      end else begin
        state_next.stepcnt = state_reg.stepcnt + 1'b1;
      end
    end

    // RQ11 - lead angle of 32 steps
    base = dir_s ? pos_add(state_reg.pos, 8'(POSITIONS - {3'b000, lead_s}))
                 : pos_add(state_reg.pos, {3'b000, lead_s});
    sh = dir_s ? PHASE_SHIFT : 8'(PHASE_SHIFT << 1);
    pat = SQUARE_PATTERN[state_reg.sector];
    if (dir_s) begin
      pat = {pat[2:0], pat[5:3]};
    end
    sq_on = {1'b0, speed_s[7:1]} > tri_lvl;
    ph = base;
    for (int i = 0; i < 3; i++) begin
      // RQ3 - sine compare with triangle
      pwm_up = mod_level(ph, speed_s) > tri_lvl;
      ph = pos_add(ph, sh);
      if (blocked) begin
        // RQ18 - no pulses while blocked
        state_next.want_up[i] = 1'b0;
        state_next.want_lo[i] = 1'b0;
      end else if (speed_low) begin
        // RQ4 - bootstrap pulse only
        state_next.want_up[i] = 1'b0;
        state_next.want_lo[i] = boot_win;
      end else if (sine_mode) begin
        // RQ5 - PWM passed straight
        state_next.want_up[i] = pwm_up;
        state_next.want_lo[i] = !pwm_up;
      end else if (boot_win) begin
        // RQ6 - forced lower in square
        state_next.want_up[i] = 1'b0;
        state_next.want_lo[i] = 1'b1;
      end else begin
        // RQ1 - 120 degree square pattern
        state_next.want_up[i] = pat[i] && sq_on;
        state_next.want_lo[i] = pat[3 + i];
      end
    end

    // RQ9 - legs keep dead time always
    on = {lo_on, up_on} & {6{!blocked}};
    // RQ13 - polarity applied last
    state_next.out = pol_s ? on : ~on;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.reverse_detect_flag <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign upper_a_o = state_reg.out[0];
  assign upper_b_o = state_reg.out[1];
  assign upper_c_o = state_reg.out[2];
  assign lower_a_o = state_reg.out[3];
  assign lower_b_o = state_reg.out[4];
  assign lower_c_o = state_reg.out[5];
  assign reverse_detect_flag_o = state_reg.reverse_detect_flag;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_trip;
    oc_s;
  endsequence

  sequence s_carrier_end;
    state_reg.oc_block && !oc_s && state_reg.cpos == CARRIER_LAST;
  endsequence

  property p_carrier_wrap;
    state_reg.cpos == CARRIER_LAST |=> state_reg.cpos == 8'h00;
  endproperty
  a_carrier_wrap: assert property (p_carrier_wrap) else $error("carrier did not wrap at 252"); // RQ12

  property p_oc_block;
    s_trip |=> state_reg.oc_block ##1 state_reg.out == $past({6{~pol_s}});
  endproperty
  a_oc_block: assert property (p_oc_block) else $error("over-current did not block"); // RQ16

  property p_oc_release;
    s_carrier_end |=> !state_reg.oc_block;
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("block not released at carrier end"); // RQ16

  property p_gate_block;
    !gbn_s |=> state_reg.out == $past({6{~pol_s}});
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("outputs active under gate block"); // RQ17

  property p_no_boot_blocked;
    !gbn_s |=> state_reg.want_lo == 3'h0;
  endproperty
  a_no_boot_blocked: assert property (p_no_boot_blocked) else $error("bootstrap pulse while blocked"); // RQ18

  property p_hall_fault;
    !hall_ok |=> state_reg.out == $past({6{~pol_s}});
  endproperty
  a_hall_fault: assert property (p_hall_fault) else $error("outputs active on bad Hall code"); // RQ19

  property p_boot_pulse;
    speed_low && !blocked && boot_win |=> state_reg.want_lo == 3'h7 && state_reg.want_up == 3'h0;
  endproperty
  a_boot_pulse: assert property (p_boot_pulse) else $error("bootstrap pulse missing"); // RQ4

  property p_edge_restart;
    hall_edge |=> state_reg.stepcnt == '0 && state_reg.tmr == '0;
  endproperty
  a_edge_restart: assert property (p_edge_restart) else $error("edge did not restart wave"); // RQ23

  property p_slow_drop;
    state_reg.tmr == SW && !hall_edge |=> !state_reg.fast;
  endproperty
  a_slow_drop: assert property (p_slow_drop) else $error("sine kept below switch-over"); // RQ2

  property p_rev_hold;
    !(hall_edge && state_reg.edges == SECTOR_LAST) |=> $stable(state_reg.reverse_detect_flag);
  endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("reverse flag changed mid-turn"); // RQ14
endmodule
`default_nettype wire

// [testbench/hall_sensor_model.sv]
// Hall sensor model: six-step position code, run/stop, reverse and fault patterns
`timescale 1ns/100ps
`default_nettype none
module hall_sensor_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic reverse_i,
  input wire logic fault_i,
  input wire logic fault_level_i,
  input wire logic [15:0] period_i,
  output logic hall_a_o,
  output logic hall_b_o,
  output logic hall_c_o,
  output logic [2:0] sector_o
);
  import commutator_pkg::*;
  logic [15:0] tick;
  // ==========================================================================
  // Sector stepping
  // one edge per sector
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tick <= 16'h0000;
      sector_o <= 3'h0;
    end else if (run_i && tick >= period_i - 16'h0001) begin
      tick <= 16'h0000;
      if (reverse_i) begin
        sector_o <= (sector_o == 3'h0) ? SECTOR_LAST : sector_o - 3'h1;
      end else begin
        sector_o <= (sector_o == SECTOR_LAST) ? 3'h0 : sector_o + 3'h1;
      end
    end else if (run_i) begin
      tick <= tick + 16'h0001;
    end
  end
  // ==========================================================================
  // Pin levels
  // invalid code only on command
  assign {hall_a_o, hall_b_o, hall_c_o} = fault_i ? {3{fault_level_i}} : HALL_CODE[sector_o];
endmodule
`default_nettype wire

// [testbench/sine_pwm_bldc_commutator_tb.sv]
// Self-checking bench for the Hall-driven square/sine commutator
`timescale 1ns/100ps
`default_nettype none
module sine_pwm_bldc_commutator_tb;
  import commutator_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic dir_sel = 1'b0;
  logic dt_sel = 1'b1;
  logic pol = 1'b1;
  logic blk_n = 1'b1;
  logic oc = 1'b0;
  logic [7:0] speed = 8'h00;
  logic [4:0] lead = 5'h00;
  logic hall_run = 1'b0;
  logic hall_rev = 1'b0;
  logic hall_bad = 1'b0;
  logic hall_lvl = 1'b0;
  logic [15:0] hall_per = 16'h044C;
  logic ha, hb, hc, ua, ub, uc, la, lb, lc, reverse_detect_flag;
  logic [2:0] hall_sector, sec_q, lo_q, last_up;
  logic pol_q;
  logic [5:0] outs;
  logic [2:0] up_w, lo_w;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 67932;
  int gap [3];
  int dt_need [3];
  int dt_exact [2] = '{0, 0};
  int pol_age = 0, sec_age = 0, uc_cnt = 0, n, w, per, n0;
  int c_per [4] = '{1100, 900, 900, 900};
  logic [3:0] c_dir = 4'hC;
  logic [3:0] c_hrev = 4'h8;
  logic [3:0] c_sine = 4'hA;
  assign outs = {ua, ub, uc, la, lb, lc};
  assign up_w = {uc, ub, ua};
  assign lo_w = {lc, lb, la};
  always #25 clk_sys_i = ~clk_sys_i;
  // ==========================================================================
  // Instances
  sine_pwm_bldc_commutator #(.SWITCH_CYCLES(1024)) sine_pwm_bldc_commutator_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hall_phase_a_i(ha), .hall_phase_b_i(hb), .hall_phase_c_i(hc),
    .direction_select_i(dir_sel), .dead_time_select_i(dt_sel), .output_polarity_select_i(pol),
    .gate_block_input_n_i(blk_n), .overcurrent_trip_i(oc), .speed_command_i(speed),
    .lead_angle_input_i(lead), .upper_a_o(ua), .upper_b_o(ub), .upper_c_o(uc), .lower_a_o(la),
    .lower_b_o(lb), .lower_c_o(lc), .reverse_detect_flag_o(reverse_detect_flag));
  hall_sensor_model hall_sensor_model_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(hall_run), .reverse_i(hall_rev), .fault_i(hall_bad),
    .fault_level_i(hall_lvl), .period_i(hall_per), .hall_a_o(ha), .hall_b_o(hb), .hall_c_o(hc),
    .sector_o(hall_sector));
  // ==========================================================================
  // Tasks
  task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic pulse_c();
    n = 0;
    while (lc === pol && n < 600) begin cyc(1); n++; end
    while (lc !== pol && n < 1200) begin cyc(1); n++; end
    w = 0;
    while (lc === pol && w < 600) begin cyc(1); w++; end
    per = w;
    while (lc !== pol && per < 600) begin cyc(1); per++; end
  endtask
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Leg monitor
  always @(posedge clk_sys_i) begin
    if (pol !== pol_q || rst_i) pol_age = 0;
    else if (pol_age < 100) pol_age++;
    pol_q = pol;
    sec_age = (hall_sector !== sec_q) ? 0 : sec_age + 1;
    sec_q = hall_sector;
    if (hall_sector == 3'h0 && sec_age > 10 && uc === pol) uc_cnt++;
    for (int i = 0; i < 3; i++) begin
      if (pol_age < 10) last_up[i] = 1'b0;
      else begin
        check_in(32'(up_w[i] === pol && lo_w[i] === pol), 32'h0, 32'h0);
        if (lo_w[i] === pol && lo_q[i] !== pol && last_up[i]) begin
          check_in(32'(gap[i]), 32'(dt_need[i]), 32'h3E7);
          if (gap[i] == dt_need[i]) dt_exact[dt_need[i] == 32'(DEAD_CYCLES_HIGH)]++;
          last_up[i] = 1'b0;
        end
        if (up_w[i] === pol) begin
          gap[i] = 0;
          last_up[i] = 1'b1;
          dt_need[i] = dt_sel ? 32'(DEAD_CYCLES_HIGH) : 32'(DEAD_CYCLES_LOW);
        end else gap[i]++;
      end
    end
    lo_q = lo_w;
  end
  // ==========================================================================
  // Watchdog
  initial begin
    cyc(75000);
    n_errors++;
    summarize();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    // speed command held low through start-up
    cyc(3);
    check_in(32'({outs, reverse_detect_flag}), 32'h01, 32'h01);
    cyc(1);
    rst_i <= 1'b0;
    cyc(10);
    for (int p = 1; p >= 0; p--) begin
      for (int k = 0; k < 2; k++) begin
        pol <= p[0];
        dt_sel <= p[0];
        blk_n <= 1'b0;
        speed <= k ? (8'($random(seed)) | 8'h40) : (8'($random(seed)) & SPEED_LOW_CODE_DEFAULT);
        cyc(5);
        check_in(32'(outs), 32'({6{~p[0]}}), 32'({6{~p[0]}}));
        n = 0;
        repeat (300) begin cyc(1); if (outs !== {6{~p[0]}}) n++; end
        check_in(32'(n), 32'h0, 32'h0);
        blk_n <= 1'b1;
        pulse_c();
        check_in(32'(w), 32'(FORCED_LOWER_ON_CYCLES - 1), 32'(FORCED_LOWER_ON_CYCLES + 1));
        check_in(32'(per), 32'(CARRIER_CYCLES), 32'(CARRIER_CYCLES));
      end
    end
    for (int f = 0; f < 2; f++) begin
      hall_bad <= 1'b1;
      hall_lvl <= f[0];
      cyc(6);
      check_in(32'(outs), 32'({6{~pol}}), 32'({6{~pol}}));
      hall_bad <= 1'b0;
      // Skip the cut bootstrap pulse at release
      cyc(30);
      pulse_c();
      check_in(32'(per), 32'(CARRIER_CYCLES), 32'(CARRIER_CYCLES));
    end
    oc <= 1'b1;
    cyc(1);
    oc <= 1'b0;
    cyc(5);
    check_in(32'(outs), 32'({6{~pol}}), 32'({6{~pol}}));
    n = 0;
    while (outs === {6{~pol}} && n < 600) begin cyc(1); n++; end
    check_in(32'(n), 32'h0, 32'(CARRIER_CYCLES));
    speed <= 8'h80 | (8'($random(seed)) & 8'h1F);
    lead <= 5'($random(seed));
    hall_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      hall_per <= 16'(c_per[i]);
      dir_sel <= c_dir[i];
      hall_rev <= c_hrev[i];
      cyc(8 * c_per[i]);
      check_in(32'(reverse_detect_flag), 32'(c_dir[i] ^ c_hrev[i]), 32'(c_dir[i] ^ c_hrev[i]));
      n0 = uc_cnt;
      cyc(6 * c_per[i]);
      check_in(32'(uc_cnt > n0), 32'(c_sine[i]), 32'(c_sine[i]));
    end
    check_in(32'(dt_exact[0] > 0 && dt_exact[1] > 0), 32'h1, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
